// ### inc/rclv_pkg.sv
package rclv_pkg;

    // register bus shape
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W  = 8;

    // printed offsets are register indices, byte address is four times that
    localparam logic [ADDR_W-1:0] CONTROL_IDX = 8'h00;
    localparam logic [ADDR_W-1:0] CAUSE_IDX   = 8'h01;
    localparam logic [ADDR_W-1:0] CONTROL_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] CAUSE_ADDR   = 8'h04;

    // reset_control_reg fields
    localparam int LV_FLAG_BIT      = 4;
    localparam int LV_IRQ_EN_BIT    = 3;
    localparam int LV_RESET_EN_BIT  = 2;
    localparam int LV_DETECT_EN_BIT = 0;

    localparam logic LV_IRQ_EN_RST    = 1'b0;
    localparam logic LV_RESET_EN_RST  = 1'b1;
    localparam logic LV_DETECT_EN_RST = 1'b1;

    // reset_cause_reg fields
    localparam int NUM_CAUSES          = 7;
    localparam int LV_RESET_CAUSE_BIT  = 6;
    localparam int PROGRAM_CAUSE_BIT   = 5;
    localparam int WATCHDOG_CAUSE_BIT  = 4;
    localparam int POWER_UP_CAUSE_BIT  = 3;
    localparam int OUTSIDE_PIN_BIT     = 2;
    localparam int REF_FAILURE_BIT     = 1;
    localparam int PLL_UNLOCK_BIT      = 0;

    // power-on leaves power-up and low-voltage set, all others clear
    localparam logic [NUM_CAUSES-1:0] POWER_UP_PATTERN = 7'h48;

    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

endpackage

// ### src/rclv_cause_latch.sv
`timescale 1ns/1ps
module rclv_cause_latch
    import rclv_pkg::*;
(
    input  wire logic                            clock,
    input  wire logic                            rst,
    input  wire logic                            por_req,
    input  wire logic [rclv_pkg::NUM_CAUSES-1:0] pending,
    output logic      [rclv_pkg::NUM_CAUSES-1:0] cause_reg
);
    import rclv_pkg::*;

    logic por_hold_reg;
    logic any_pending_d_reg;
    logic entry;
    logic [NUM_CAUSES-1:0] cause_next;

    // no async reset here: the record must survive the very reset it describes
    always_ff @(posedge clock) begin
        if (por_req) begin
            por_hold_reg <= 1'b1;
        end else if (!rst) begin
            por_hold_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        any_pending_d_reg <= |pending;
    end

    assign entry = (|pending) && !any_pending_d_reg;

    genvar i;
    generate
        for (i = 0; i < NUM_CAUSES; i++) begin : g_cause
            always_comb begin
                if (por_req || por_hold_reg) begin
                    cause_next[i] = POWER_UP_PATTERN[i];
                end else if (entry) begin
                    cause_next[i] = pending[i];
                end else begin
                    cause_next[i] = cause_reg[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        cause_reg <= cause_next;
    end

endmodule

// ### src/rclv_top.sv
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
// Overview of operation
// - with detect on, low supply sets sticky flag bit 4; only writing one or power-on clears it.
// - interrupt requested when flag set, detect and irq enabled, reset enable clear.
// - reset does not clear the flag; low supply keeps the part in reset.
// - detect and reset enables come up set, so low supply holds chip in reset.
// - irq enable bit 3 gates the interrupt, ignored while detect is off.
// - reset enable bit 2 gates the low-voltage reset, ignored while detect is off.
// - with both enabled, reset wins over interrupt.
// - bit 0 switches low-voltage detection on or off.
// - on reset entry capture one per pending source, zero for the rest.
// - several cause bits may be set together.
// - each later reset overwrites the whole cause record.
// - cause register readable any time; writes are ignored.
// - cause bit 6 marks a low-voltage reset.
// - cause bit 5 marks a software reset.
// - cause bit 4 marks a watchdog timeout reset.
// - cause bit 3 marks a power-on reset.
// - cause bit 2 marks an external reset pin reset.
// - cause bit 1 marks a loss-of-clock reset.
// - cause bit 0 marks a loss-of-lock reset.
// - power-on sets power-up and low-voltage causes only, ignoring others meanwhile.
module rclv_top
    import rclv_pkg::*;
(
    input  wire logic                        clock,
    input  wire logic                        rst,
    input  wire logic [rclv_pkg::ADDR_W-1:0] addr,
    input  wire logic [rclv_pkg::DATA_W-1:0] wdata,
    input  wire logic                        wr_en,
    input  wire logic                        rd_en,
    output logic      [rclv_pkg::DATA_W-1:0] rdata,
    input  wire logic                        low_supply,
    input  wire logic                        por_req,
    input  wire logic                        reset_in_pin_req,
    input  wire logic                        watchdog_req,
    input  wire logic                        program_req,
    input  wire logic                        ref_failure_req,
    input  wire logic                        pll_unlock_req,
    input  wire logic                        edge_port_irq0,
    output logic                             lv_irq,
    output logic                             shared_irq,
    output logic                             lv_reset_req
);
    import rclv_pkg::*;

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] target);
        reg_hit = (a == target);
    endfunction

    logic low_voltage_detect_enable_reg;
    logic low_voltage_irq_enable_reg;
    logic low_voltage_reset_enable_reg;
    logic low_voltage_flag_reg;
    logic low_voltage_flag_next;
    logic control_write;
    logic lv_reset_term;
    logic lv_irq_term;
    logic [NUM_CAUSES-1:0] pending;
    logic [NUM_CAUSES-1:0] cause_value;
    logic [REG_W-1:0] control_view;
    logic [REG_W-1:0] cause_view;
    logic [DATA_W-1:0] rdata_next;
    logic lv_irq_reg;
    logic shared_irq_reg;
    logic lv_reset_req_reg;
    logic [DATA_W-1:0] rdata_reg;

    assign control_write = wr_en && reg_hit(addr, CONTROL_ADDR);

    // enables; detect and reset enable come out of reset set
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            low_voltage_detect_enable_reg <= LV_DETECT_EN_RST;
            low_voltage_reset_enable_reg  <= LV_RESET_EN_RST;
            low_voltage_irq_enable_reg    <= LV_IRQ_EN_RST;
        end else if (control_write) begin
            low_voltage_detect_enable_reg <= wdata[LV_DETECT_EN_BIT];
            low_voltage_reset_enable_reg  <= wdata[LV_RESET_EN_BIT];
            low_voltage_irq_enable_reg    <= wdata[LV_IRQ_EN_BIT];
        end
    end

    // sticky flag; set wins over a same-cycle clear
    always_comb begin
        low_voltage_flag_next = low_voltage_flag_reg;
        if (control_write && wdata[LV_FLAG_BIT]) begin
            low_voltage_flag_next = 1'b0;
        end
        if (low_voltage_detect_enable_reg && low_supply) begin
            low_voltage_flag_next = 1'b1;
        end
    end

    // deliberately outside rst; only power-up gives it a known start
    always_ff @(posedge clock) begin
        if (por_req) begin
            low_voltage_flag_reg <= 1'b0;
        end else begin
            low_voltage_flag_reg <= low_voltage_flag_next;
        end
    end

    // reset enable only counts while detection is on
    assign lv_reset_term = low_voltage_detect_enable_reg && low_voltage_reset_enable_reg
                           && low_supply;

    // reset enable suppresses the interrupt
    assign lv_irq_term = low_voltage_detect_enable_reg && low_voltage_irq_enable_reg
                         && !low_voltage_reset_enable_reg && low_voltage_flag_reg;

    // no async reset: must keep requesting reset while rst is held
    always_ff @(posedge clock) begin
        lv_reset_req_reg <= lv_reset_term;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lv_irq_reg     <= 1'b0;
            shared_irq_reg <= 1'b0;
        end else begin
            lv_irq_reg     <= lv_irq_term;
            shared_irq_reg <= lv_irq_term || edge_port_irq0;
        end
    end

    // pending sources, packed in cause-register order
    always_comb begin
        pending                     = '0;
        pending[LV_RESET_CAUSE_BIT] = lv_reset_term;
        pending[PROGRAM_CAUSE_BIT]  = program_req;
        pending[WATCHDOG_CAUSE_BIT] = watchdog_req;
        pending[POWER_UP_CAUSE_BIT] = por_req;
        pending[OUTSIDE_PIN_BIT]    = reset_in_pin_req;
        pending[REF_FAILURE_BIT]    = ref_failure_req;
        pending[PLL_UNLOCK_BIT]     = pll_unlock_req;
    end

    rclv_cause_latch u_cause (
        .clock     (clock),
        .rst       (rst),
        .por_req   (por_req),
        .pending   (pending),
        .cause_reg (cause_value)
    );

    always_comb begin
        control_view                   = '0;
        control_view[LV_FLAG_BIT]      = low_voltage_flag_reg;
        control_view[LV_IRQ_EN_BIT]    = low_voltage_irq_enable_reg;
        control_view[LV_RESET_EN_BIT]  = low_voltage_reset_enable_reg;
        control_view[LV_DETECT_EN_BIT] = low_voltage_detect_enable_reg;
        cause_view                     = {1'b0, cause_value};
    end

    // cause register has no write path at all
    always_comb begin
        rdata_next = READ_ZERO;
        if (rd_en) begin
            if (reg_hit(addr, CONTROL_ADDR)) begin
                rdata_next = {{(DATA_W-REG_W){1'b0}}, control_view};
            end else if (reg_hit(addr, CAUSE_ADDR)) begin
                rdata_next = {{(DATA_W-REG_W){1'b0}}, cause_view};
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_reg <= READ_ZERO;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata        = rdata_reg;
    assign lv_irq       = lv_irq_reg;
    assign shared_irq   = shared_irq_reg;
    assign lv_reset_req = lv_reset_req_reg;

endmodule

// ### tb/rclv_top_monitor.sv
`timescale 1ns/1ps
module rclv_top_monitor
    import rclv_pkg::*;
(
    input wire logic                        clock,
    input wire logic                        rst,
    input wire logic [rclv_pkg::ADDR_W-1:0] addr,
    input wire logic [rclv_pkg::DATA_W-1:0] wdata,
    input wire logic                        wr_en,
    input wire logic                        rd_en,
    input wire logic [rclv_pkg::DATA_W-1:0] rdata,
    input wire logic                        low_supply,
    input wire logic                        edge_port_irq0,
    input wire logic                        lv_irq,
    input wire logic                        shared_irq,
    input wire logic                        lv_reset_req
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    a_rdata_idle_zero: assert property (!$past(rd_en) |-> rdata == '0)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (rd_en && addr != CONTROL_ADDR && addr != CAUSE_ADDR |=> rdata == '0)
        else $error("unmapped read not zero");
    a_upper_bits_zero: assert property (rd_en |=> rdata[31:7] == '0)
        else $error("reserved read bits set");
    a_control_reserved: assert property (rd_en && addr == CONTROL_ADDR |=> rdata[6:5] == 2'h0 && !rdata[1])
        else $error("reserved control bits set");
    a_reset_needs_low: assert property (lv_reset_req |-> $past(low_supply))
        else $error("low-voltage reset without low supply");
    a_reset_over_irq: assert property (!(lv_irq && lv_reset_req))
        else $error("interrupt and reset together");
    a_shared_vector: assert property (shared_irq == (lv_irq || $past(edge_port_irq0)))
        else $error("shared interrupt mismatch");
    a_clear_drops_irq: assert property (wr_en && addr == CONTROL_ADDR && wdata[LV_FLAG_BIT] && !low_supply |-> ##2 !lv_irq)
        else $error("interrupt survives flag clear");
    a_hold_in_reset: assert property (disable iff (1'b0) rst && $past(rst) && low_supply |=> lv_reset_req)
        else $error("low supply not held in reset");
    cover property ($rose(lv_irq));
    cover property ($rose(lv_reset_req));
    cover property ($rose(shared_irq) && !lv_irq);
endmodule
bind rclv_top rclv_top_monitor u_mon (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .low_supply(low_supply), .edge_port_irq0(edge_port_irq0), .lv_irq(lv_irq),
    .shared_irq(shared_irq), .lv_reset_req(lv_reset_req));

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import rclv_pkg::*;
    logic              clock;
    logic              rst;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr_en;
    logic              rd_en;
    logic [DATA_W-1:0] rdata;
    logic              low_supply;
    logic              por_req;
    logic [5:0]        src;
    logic              edge_port_irq0;
    logic              lv_irq;
    logic              shared_irq;
    logic              lv_reset_req;
    int                errors = 0;
    int                checks = 0;
    int                cycles = 0;
    logic [7:0]        pats [4] = '{8'h30, 8'h04, 8'h02, 8'h01};

    rclv_top DUT (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .low_supply(low_supply), .por_req(por_req), .reset_in_pin_req(src[2]),
        .watchdog_req(src[4]), .program_req(src[5]), .ref_failure_req(src[1]), .pll_unlock_req(src[0]),
        .edge_port_irq0(edge_port_irq0), .lv_irq(lv_irq), .shared_irq(shared_irq), .lv_reset_req(lv_reset_req));

    task automatic print_verdict;
        if (errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_pin(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= {24'h0, d};
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        check(rdata, {24'h0, exp});
    endtask
    task automatic dip(input logic exp_irq, input logic exp_rst);
        @(posedge clock);
        low_supply <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
        check_pin(lv_irq, exp_irq);
        check_pin(lv_reset_req, exp_rst);
        @(posedge clock);
        low_supply <= 1'b0;
    endtask

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            errors++;
            print_verdict();
        end
    end

    initial begin
        rst = 1'b1;
        por_req = 1'b1;
        addr = '0;
        wdata = '0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        low_supply = 1'b0;
        src = 6'h00;
        edge_port_irq0 = 1'b0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        por_req <= 1'b0;
        rdc(CAUSE_ADDR, 8'h48);
        rdc(CONTROL_ADDR, 8'h05);
        wr(CAUSE_ADDR, 8'hFF);
        rdc(CAUSE_ADDR, 8'h48);
        rdc(8'h08, 8'h00);
        foreach (pats[i]) begin
            @(posedge clock);
            src <= pats[i][5:0];
            @(posedge clock);
            src <= 6'h00;
            rdc(CAUSE_ADDR, pats[i]);
        end
        wr(CONTROL_ADDR, 8'h09);
        dip(1'b1, 1'b0);
        #1;
        check_pin(shared_irq, 1'b1);
        rdc(CONTROL_ADDR, 8'h19);
        wr(CONTROL_ADDR, 8'h09);
        rdc(CONTROL_ADDR, 8'h19);
        wr(CONTROL_ADDR, 8'h19);
        rdc(CONTROL_ADDR, 8'h09);
        check_pin(lv_irq, 1'b0);
        wr(CONTROL_ADDR, 8'h0C);
        dip(1'b0, 1'b0);
        rdc(CONTROL_ADDR, 8'h0C);
        wr(CONTROL_ADDR, 8'h0D);
        dip(1'b0, 1'b1);
        rdc(CAUSE_ADDR, 8'h40);
        @(posedge clock);
        rst <= 1'b1;
        low_supply <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        low_supply <= 1'b0;
        rdc(CONTROL_ADDR, 8'h15);
        @(posedge clock);
        edge_port_irq0 <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check_pin(shared_irq, 1'b1);
        check_pin(lv_irq, 1'b0);
        print_verdict();
    end
endmodule
